// >>> btdsp_device.sv
// Burst memory device end of the link: command decode, write capture,
// two-array storage and read launch.
// Assumes the host keeps its side of the link and shares ref_clk.
//
// Function
// - Loop enabled: read latency one and half
// - Loop disabled: read latency one cycle
// - Write words captured on both input edges
// - Reads launched on output clock, else input
// - Controls sampled on positive input edge only
// - Every access is two 18-bit words
// - Read high with strobe low starts read
// - Read address stored, LSB seeds burst counter
// - First read word after next positive edge
// - Second read word from burst counter address
// - Read command accepted every positive edge
// - Finish reads, then release the data wire
// - Read low with strobe low starts write
// - First write word latched with lane selects
// - Second word latched, 36 bits then committed
// - Write command accepted every positive edge
// - Deselected writes finish, then inputs ignored
// - Lane selects sampled with each write word
// - Deselected lane keeps stored contents
// - Host leaves idle slot before reads-to-writes
// - Both output clocks high at reset: single
`timescale 1ns/100ps
module btdsp_device #(
  parameter int ADDR_W = btdsp_pkg::ADDR_W   // Word address width.
) (
  // Clock and reset.
  input  wire logic  ref_clk,
  input  wire logic  resetn,
  // Status to the board.
  output logic       singleClkMode,
  // Link to the host.
  btdsp_link_if.device link
);
  localparam int W   = btdsp_pkg::WORD_W;   // Word width.
  localparam int RWS = ADDR_W - 1;          // Row address width.
  localparam int D   = btdsp_pkg::PIPE_D;   // Pipeline depth.

  // ********************
  // Storage
  // ********************
  // Two arrays of rows; the address LSB picks the array.
  logic [W-1:0]      bank0 [2**RWS];        // Array for even word addresses.
  logic [W-1:0]      bank1 [2**RWS];        // Array for odd word addresses.

  logic              strapDone_q;           // Strap has been caught.
  logic              singleClk_q;           // Output timing follows input clocks.
  logic              outSlotPos;            // Positive output slot in this cycle.
  logic              dllOn;                 // Long read latency selected.
  logic              cmdSlot;               // A command is on the pins now.
  logic              rdCmd;                 // Read command this edge.
  logic              wrCmd;                 // Write command this edge.
  logic [D:1]        rdV_q;                 // Read burst stage valid bits.
  logic [ADDR_W-1:0] rdA_q [1:D];           // Read address per stage.
  logic [D:1]        wrV_q;                 // Write burst stage valid bits.
  logic [ADDR_W-1:0] wrA_q [1:D];           // Write address per stage.
  logic [W-1:0]      wd_q;                  // First write word held.
  logic [1:0]        wl_q;                  // Lane selects of the first word.
  logic [1:0]        s1;                    // Stage that loads read word one.
  logic              launchOk;              // Output slot matches word one.
  logic [W-1:0]      dataOut_q;             // Read word on the wire.
  logic              dataOe_q;              // Device drives the wire.

  // Row of a burst, shared by both words.
  function automatic logic [RWS-1:0] rowOf(input logic [ADDR_W-1:0] a);
    rowOf = a[ADDR_W-1:1];
  endfunction

  // Stored word of a burst; the second word flips the address LSB.
  // With the short latency a fetch can meet the commit of the write just
  // before it, so that commit is forwarded instead of reading stale bits.
  function automatic logic [W-1:0] rdWord(input logic [ADDR_W-1:0] a, input logic second);
    logic         odd; // Array that holds this word.
    logic [W-1:0] w;   // Word as it stands after this edge.
    odd = a[0] ^ second;
    w   = odd ? bank1[rowOf(a)] : bank0[rowOf(a)];
    if (wrV_q[btdsp_pkg::WR_W2_STAGE] && (rowOf(wrA_q[D]) == rowOf(a)))
    begin
      if (odd == wrA_q[D][0])
        w = laneMerge(w, wd_q, wl_q);
      else
        w = laneMerge(w, link.busData, link.byteLaneSelN);
    end
    rdWord = w;
  endfunction

  // Lane merge; an active-low select writes its lane, else the old bits stay.
  function automatic logic [W-1:0] laneMerge(input logic [W-1:0] old, input logic [W-1:0] nw,
                                             input logic [1:0] selN);
    laneMerge = old;
    if (!selN[0])
      laneMerge[btdsp_pkg::LANE_W-1:0] = nw[btdsp_pkg::LANE_W-1:0];
    if (!selN[1])
      laneMerge[W-1:btdsp_pkg::LANE_W] = nw[W-1:btdsp_pkg::LANE_W];
  endfunction

  // ********************
  // Clock mode strap
  // ********************
  // Caught once on the first edge after reset release, never again,
  // so a later glitch on the output clocks cannot change the mode.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      strapDone_q <= 1'b0;
      singleClk_q <= 1'b0;
    end
    else if (!strapDone_q)
    begin
      strapDone_q <= 1'b1;
      singleClk_q <= link.outputTimingPos && link.outputTimingNeg;
    end
  end

  // Output timing reference: output clocks, or input clocks in single mode.
  assign outSlotPos = singleClk_q ? link.inputTimingPos : link.outputTimingPos;
  assign dllOn      = link.loopDisableN;

  // ********************
  // Command decode
  // ********************
  // Controls are looked at only in the positive input slot.
  assign cmdSlot = link.inputTimingPos && !link.loadStrobeN;
  assign rdCmd   = cmdSlot && link.readNotWrite;
  assign wrCmd   = cmdSlot && !link.readNotWrite;

  // ********************
  // Read pipeline
  // ********************
  // A new read may enter at every positive slot; stages shift each cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rdV_q <= '0;
    else
      rdV_q <= {rdV_q[D-1:1], rdCmd};
  end

  // Read address register; the LSB travels as the burst counter seed.
  always_ff @(posedge ref_clk)
  begin
    rdA_q[1] <= link.addr;
    for (int k = 2; k <= D; k++)
      rdA_q[k] <= rdA_q[k-1];
  end

  // Word one loads one stage later when the loop is enabled.
  assign s1 = dllOn ? 2'(btdsp_pkg::RD_LOAD_ON) : 2'(btdsp_pkg::RD_LOAD_OFF);
  // Word one lands in the negative output slot with the loop on,
  // in the positive slot with it off.
  assign launchOk = dllOn ? outSlotPos : !outSlotPos;

  // ********************
  // Read launch
  // ********************
  // The wire is driven only while a burst word is due, so it is
  // released right after the last word of the last pending read.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      dataOut_q <= '0;
      dataOe_q  <= 1'b0;
    end
    else if (rdV_q[s1] && launchOk)
    begin
      // First word from the presented address.
      dataOut_q <= rdWord(rdA_q[s1], 1'b0);
      dataOe_q  <= 1'b1;
    end
    else if (rdV_q[s1 + 2'h1])
    begin
      // Second word from the burst counter address.
      dataOut_q <= rdWord(rdA_q[s1 + 2'h1], 1'b1);
      dataOe_q  <= 1'b1;
    end
    else
    begin
      dataOe_q  <= 1'b0;
    end
  end

  // ********************
  // Write pipeline
  // ********************
  // A new write may enter at every positive slot.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      wrV_q <= '0;
    else
      wrV_q <= {wrV_q[D-1:1], wrCmd};
  end

  // Write address register with its burst counter seed.
  always_ff @(posedge ref_clk)
  begin
    wrA_q[1] <= link.addr;
    for (int k = 2; k <= D; k++)
      wrA_q[k] <= wrA_q[k-1];
  end

  // First word and its lane selects, in the positive slot after the command.
  // Outside a pending burst the data pins are ignored.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wd_q <= '0;
      wl_q <= btdsp_pkg::LANES_OFF;
    end
    else if (wrV_q[btdsp_pkg::WR_W1_STAGE])
    begin
      wd_q <= link.busData;
      wl_q <= link.byteLaneSelN;
    end
  end

  // Second word comes in the negative slot and both words commit at once;
  // a fetch in this same cycle is served by forwarding.
  always_ff @(posedge ref_clk)
  begin
    if (wrV_q[btdsp_pkg::WR_W2_STAGE])
    begin
      if (wrA_q[D][0])
      begin
        bank1[rowOf(wrA_q[D])] <= laneMerge(bank1[rowOf(wrA_q[D])], wd_q, wl_q);
        bank0[rowOf(wrA_q[D])] <= laneMerge(bank0[rowOf(wrA_q[D])], link.busData, link.byteLaneSelN);
      end
      else
      begin
        bank0[rowOf(wrA_q[D])] <= laneMerge(bank0[rowOf(wrA_q[D])], wd_q, wl_q);
        bank1[rowOf(wrA_q[D])] <= laneMerge(bank1[rowOf(wrA_q[D])], link.busData, link.byteLaneSelN);
      end
    end
  end

  // ********************
  // Outputs
  // ********************
  // With the loop on, a write right after a read is safe only because the host idles a slot.
  assign link.devData  = dataOut_q;
  assign link.devOe    = dataOe_q;
  assign singleClkMode = singleClk_q;
endmodule // btdsp_device

// >>> btdsp_host.sv
// Host memory controller end of the burst link.
// Assumes a user that offers one burst command at a time with valid and ready.
`timescale 1ns/100ps
module btdsp_host #(
  parameter bit DLL_ON     = 1'b1,  // Drive the loop-enable strap high.
  parameter bit SINGLE_CLK = 1'b0,  // Tie both output clocks high.
  parameter int FIFO_DEPTH = 2      // Read buffer entries.
) (
  // Clock and reset.
  input  wire logic                          ref_clk,
  input  wire logic                          resetn,
  // Burst command from the user.
  input  wire logic                          cmdValid,
  output logic                               cmdReady,
  input  wire logic                          cmdWrite,
  input  wire logic [btdsp_pkg::ADDR_W-1:0]  cmdAddr,
  input  wire logic [btdsp_pkg::WORD_W-1:0]  cmdData0,
  input  wire logic [btdsp_pkg::WORD_W-1:0]  cmdData1,
  input  wire logic [btdsp_pkg::LANES-1:0]   cmdLaneN0,
  input  wire logic [btdsp_pkg::LANES-1:0]   cmdLaneN1,
  // Read words to the user.
  output logic                               rdValid,
  input  wire logic                          rdReady,
  output logic [btdsp_pkg::WORD_W-1:0]       rdData,
  // Link to the device.
  btdsp_link_if.host                         link
);
  localparam int WP = 2 * (btdsp_pkg::WORD_W + btdsp_pkg::LANES); // Packed write burst.
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;  // Pointer width.
  localparam int RF = DLL_ON ? btdsp_pkg::RD_FIRST_ON : btdsp_pkg::RD_FIRST_OFF;

  logic                          kPos_q;       // High in the positive input slot.
  logic                          cmdReady_q;   // Accept window for the next edge.
  logic                          loadN_q;      // Registered load strobe.
  logic                          rnw_q;        // Registered read select.
  logic [btdsp_pkg::ADDR_W-1:0]  addr_q;       // Registered address.
  logic [btdsp_pkg::WORD_W-1:0]  wData_q;      // Registered write word.
  logic [btdsp_pkg::LANES-1:0]   wLane_q;      // Registered lane selects.
  logic                          wOe_q;        // Registered data drive enable.
  logic [3:1]                    hwV_q;        // Write burst tracking.
  logic [WP-1:0]                 hw_q [1:3];   // Write burst payload per stage.
  logic [btdsp_pkg::HOST_PIPE_D:1] hrV_q;      // Read burst tracking.
  logic [btdsp_pkg::WORD_W-1:0]  mem [FIFO_DEPTH]; // Read buffer storage.
  logic [PW-1:0]                 wp_q;         // Buffer write pointer.
  logic [PW-1:0]                 rp_q;         // Buffer read pointer.
  logic [PW:0]                   cnt_q;        // Buffer fill level.
  logic [PW:0]                   cnt_d;        // Next fill level.
  logic                          rdValid_q;    // Buffer not empty.
  logic                          accept;       // Command taken at this edge.
  logic                          push;         // Read word arriving now.
  logic                          pop;          // Word leaving to the user.

  assign accept = cmdValid && cmdReady_q;
  assign push   = (hrV_q[RF+1] || hrV_q[RF+2]) && (cnt_q < (PW+1)'(FIFO_DEPTH));
  assign pop    = rdValid_q && rdReady;

  // ********************
  // Link clocks and straps
  // ********************
  // The input clock pair alternates every ref_clk cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      kPos_q <= 1'b1;
    else
      kPos_q <= !kPos_q;
  end

  assign link.inputTimingPos  = kPos_q;
  assign link.inputTimingNeg  = !kPos_q;
  assign link.outputTimingPos = SINGLE_CLK ? 1'b1 : kPos_q;
  assign link.outputTimingNeg = SINGLE_CLK ? 1'b1 : !kPos_q;
  assign link.loopDisableN    = DLL_ON;

  // ********************
  // Command issue
  // ********************
  // Ready opens only before a positive slot with no read outstanding.
  // Waiting for the read words also leaves the turnaround idle slot.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      cmdReady_q <= 1'b0;
    else
      cmdReady_q <= kPos_q && !(|hrV_q) && (cnt_d == '0);
  end

  // Strobe low for the positive slot only; read select and address hold.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      loadN_q <= 1'b1;
      rnw_q   <= 1'b1;
      addr_q  <= '0;
    end
    else
    begin
      loadN_q <= !accept;
      if (accept)
      begin
        rnw_q  <= !cmdWrite;
        addr_q <= cmdAddr;
      end
    end
  end

  // ********************
  // Write data drive
  // ********************
  // Burst tracking; stage one is the command cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      hwV_q <= '0;
    else
      hwV_q <= {hwV_q[2:1], accept && cmdWrite};
  end

  // Payload rides along with its stage bit.
  always_ff @(posedge ref_clk)
  begin
    hw_q[1] <= {cmdLaneN1, cmdData1, cmdLaneN0, cmdData0};
    hw_q[2] <= hw_q[1];
    hw_q[3] <= hw_q[2];
  end

  // Word one goes out in the next positive slot, word two right after.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wData_q <= '0;
      wLane_q <= btdsp_pkg::LANES_OFF;
      wOe_q   <= 1'b0;
    end
    else if (hwV_q[2])
    begin
      {wLane_q, wData_q} <= hw_q[2][WP/2-1:0];
      wOe_q              <= 1'b1;
    end
    else if (hwV_q[3])
    begin
      {wLane_q, wData_q} <= hw_q[3][WP-1:WP/2];
      wOe_q              <= 1'b1;
    end
    else
    begin
      wLane_q <= btdsp_pkg::LANES_OFF;
      wOe_q   <= 1'b0;
    end
  end

  assign link.loadStrobeN  = loadN_q;
  assign link.readNotWrite = rnw_q;
  assign link.addr         = addr_q;
  assign link.hostData     = wData_q;
  assign link.hostOe       = wOe_q;
  assign link.byteLaneSelN = wLane_q;

  // ********************
  // Read capture and buffer
  // ********************
  // Read tracking; words are caught on a fixed latency.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      hrV_q <= '0;
    else
      hrV_q <= {hrV_q[btdsp_pkg::HOST_PIPE_D-1:1], accept && !cmdWrite};
  end

  always_comb
  begin
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Pointers and fill level of the read buffer.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      rdValid_q <= 1'b0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == PW'(FIFO_DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == PW'(FIFO_DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q     <= cnt_d;
      rdValid_q <= (cnt_d != '0);
    end
  end

  // Buffer storage.
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wp_q] <= link.busData;
  end

  assign cmdReady = cmdReady_q;
  assign rdValid  = rdValid_q;
  assign rdData   = mem[rp_q];
endmodule // btdsp_host

// >>> btdsp_link_asserts.sv
// Checker for the link between host and burst memory device.
// Assumes it watches one link instance clocked by ref_clk.
`timescale 1ns/100ps
module btdsp_link_asserts (
  // Clock and reset.
  input wire logic                        ref_clk,
  input wire logic                        resetn,
  // Link signals.
  input wire logic                        inputTimingPos,
  input wire logic                        inputTimingNeg,
  input wire logic                        loopDisableN,
  input wire logic                        loadStrobeN,
  input wire logic                        readNotWrite,
  input wire logic [btdsp_pkg::LANES-1:0] byteLaneSelN,
  input wire logic                        hostOe,
  input wire logic                        devOe
);
  // ********************
  // Command decode
  // ********************
  logic rdCmd; // A read command taken at this edge.
  logic wrCmd; // A write command taken at this edge.
  assign rdCmd = !loadStrobeN && inputTimingPos && readNotWrite;
  assign wrCmd = !loadStrobeN && inputTimingPos && !readNotWrite;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // ********************
  // Properties
  // ********************
  // Word one sits in c+3 and word two in c+4 with the loop on.
  property p_rd_lat;
    rdCmd && loopDisableN |-> ##3 devOe [*2];
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read words late or early");
  // The device drives only for a burst that is still pending.
  property p_rd_src;
    devOe && loopDisableN |-> $past(rdCmd, 3) || $past(rdCmd, 4);
  endproperty
  a_rd_src: assert property (p_rd_src) else $error("data wire driven without a read");
  // A drive run always carries two whole words.
  property p_run_two;
    $fell(devOe) |-> $past(devOe, 2);
  endproperty
  a_run_two: assert property (p_run_two) else $error("read run shorter than two words");
  // Commands only in the positive input slot.
  property p_cmd_slot;
    !loadStrobeN |-> inputTimingPos;
  endproperty
  a_cmd_slot: assert property (p_cmd_slot) else $error("command outside positive slot");
  // A strobe lasts one cycle, so commands come at most every other slot.
  property p_cmd_gap;
    !loadStrobeN |=> loadStrobeN;
  endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("strobe held two cycles");
  // Write words follow the command in c+2 and c+3.
  property p_wr_words;
    wrCmd |-> ##2 hostOe [*2];
  endproperty
  a_wr_words: assert property (p_wr_words) else $error("write words missing");
  // Lanes are idle whenever no write word is on the wire.
  property p_lanes_idle;
    !hostOe |-> byteLaneSelN == btdsp_pkg::LANES_OFF;
  endproperty
  a_lanes_idle: assert property (p_lanes_idle) else $error("lanes active without data");
  // The host keeps off the wire while the device drives it.
  property p_no_clash;
    !(hostOe && devOe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the data wire");
  // The input clock pair alternates and stays complementary.
  property p_clk_pair;
    $past(resetn) |-> inputTimingPos != $past(inputTimingPos) && inputTimingNeg != inputTimingPos;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("input slots out of step");
  // The latency strap never moves during operation.
  property p_strap;
    loopDisableN == $past(loopDisableN);
  endproperty
  a_strap: assert property (p_strap) else $error("latency strap changed");
endmodule // btdsp_link_asserts

// >>> btdsp_link_if.sv
// Link between the host controller and the burst memory device.
// Assumes both ends share ref_clk; the data wire is resolved here.
`timescale 1ns/100ps
interface btdsp_link_if;
  // ********************
  // Link signals
  // ********************
  logic                             inputTimingPos;  // High in the positive input clock slot.
  logic                             inputTimingNeg;  // High in the negative input clock slot.
  logic                             outputTimingPos; // High in the positive output clock slot.
  logic                             outputTimingNeg; // High in the negative output clock slot.
  logic                             loopDisableN;    // Low selects the one-cycle read latency.
  logic                             loadStrobeN;     // Low marks a command.
  logic                             readNotWrite;    // High read, low write.
  logic [btdsp_pkg::ADDR_W-1:0]     addr;            // Burst start address.
  logic [btdsp_pkg::LANES-1:0]      byteLaneSelN;    // Active-low lane selects.
  logic [btdsp_pkg::WORD_W-1:0]     hostData;        // Host drive onto the data wire.
  logic                             hostOe;          // Host drives the data wire.
  logic [btdsp_pkg::WORD_W-1:0]     devData;         // Device drive onto the data wire.
  logic                             devOe;           // Device drives the data wire.
  logic [btdsp_pkg::WORD_W-1:0]     busData;         // Resolved data wire level.

  // The wire reads zero when nobody drives; device wins a clash.
  assign busData = devOe ? devData : (hostOe ? hostData : '0);

  modport device (
    input  inputTimingPos, inputTimingNeg, outputTimingPos, outputTimingNeg,
    input  loopDisableN, loadStrobeN, readNotWrite, addr, byteLaneSelN, busData,
    output devData, devOe
  );
  modport host (
    output inputTimingPos, inputTimingNeg, outputTimingPos, outputTimingNeg,
    output loopDisableN, loadStrobeN, readNotWrite, addr, byteLaneSelN,
    output hostData, hostOe,
    input  busData
  );
endinterface // btdsp_link_if

// >>> btdsp_pkg.sv
// Shared constants for the two-word burst DDR static memory port.
// Assumes both ends run on one 40 MHz ref_clk and see the same link.
package btdsp_pkg;
  // ********************
  // Word and address layout
  // ********************
  localparam int WORD_W = 18;           // Width of one burst word.
  localparam int LANE_W = 9;            // Bits governed by one lane select.
  localparam int LANES  = 2;            // Byte lane selects per word.
  localparam int ADDR_W = 20;           // Word address width, LSB picks the array.
  // ********************
  // Link pipeline timing, in ref_clk cycles after the command cycle
  // ********************
  localparam int PIPE_D        = 3;     // Device pipeline stages.
  localparam int WR_W1_STAGE   = 2;     // Stage that holds the first write word.
  localparam int WR_W2_STAGE   = 3;     // Stage that holds the second write word.
  localparam int RD_LOAD_ON    = 2;     // Stage that loads word one, loop on.
  localparam int RD_LOAD_OFF   = 1;     // Stage that loads word one, loop off.
  localparam int RD_FIRST_ON   = 3;     // Cycle of word one on the bus, loop on.
  localparam int RD_FIRST_OFF  = 2;     // Cycle of word one on the bus, loop off.
  localparam int HOST_PIPE_D   = 5;     // Host read tracking depth.
  // ********************
  // Pin levels
  // ********************
  localparam logic [LANES-1:0] LANES_ALL = 2'h0; // Both lanes enabled.
  localparam logic [LANES-1:0] LANES_OFF = 2'h3; // No lane enabled.
endpackage

// >>> tb_burst_two_ddr_sram_port.sv
// Bench joining host and device; drives the host user side.
// Assumes package, link, host, device and checker are compiled first.
`timescale 1ns/100ps
module tb_burst_two_ddr_sram_port;
  // ********************
  // Stimulus and observation
  // ********************
  logic        ref_clk  = 1'b0;   // 40 MHz clock.
  logic        resetn   = 1'b0;   // Synchronous, active low.
  logic        cmdValid = 1'b0;   // Command offered.
  logic        cmdWrite = 1'b0;   // Write when high.
  logic [19:0] cmdAddr  = 20'h0;  // Burst start address.
  logic [17:0] cmdData0 = 18'h0;  // First write word.
  logic [17:0] cmdData1 = 18'h0;  // Second write word.
  logic [1:0]  cmdLaneN0 = 2'h3;  // Lanes of word one.
  logic [1:0]  cmdLaneN1 = 2'h3;  // Lanes of word two.
  logic        rdReady  = 1'b0;   // Held low to stall the buffer.
  logic        cmdReady [2];      // Host takes a command, per pair.
  logic        rdValid [2];       // Read buffer not empty.
  logic [17:0] rdData [2];        // Head read word.
  logic        singleClkMode [2]; // Strap seen by the device.
  logic [17:0] mem [int];         // Expected array contents.
  int          nErrors  = 0;      // Mismatches.
  int          compares = 0;      // Comparisons made.
  always #12.5 ref_clk = ~ref_clk;
  // Pair 0 runs the long latency on split clocks, pair 1 the short one in single-clock mode.
  // Both take the same user stimulus; their ready windows coincide.
  for (genvar g = 0; g < 2; g++)
  begin : pair
    btdsp_link_if btdsp_link_if_i ();
    btdsp_host #(.DLL_ON(g == 0), .SINGLE_CLK(g == 1)) btdsp_host_i (.ref_clk(ref_clk), .resetn(resetn),
      .cmdValid(cmdValid), .cmdReady(cmdReady[g]), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData0(cmdData0),
      .cmdData1(cmdData1), .cmdLaneN0(cmdLaneN0), .cmdLaneN1(cmdLaneN1), .rdValid(rdValid[g]), .rdReady(rdReady),
      .rdData(rdData[g]), .link(btdsp_link_if_i));
    btdsp_device btdsp_device_i (.ref_clk(ref_clk), .resetn(resetn), .singleClkMode(singleClkMode[g]),
      .link(btdsp_link_if_i));
    // The checker's latency properties expect the long latency.
    if (g == 0)
    begin : watch
      btdsp_link_asserts btdsp_link_asserts_i (.ref_clk(ref_clk), .resetn(resetn),
        .inputTimingPos(btdsp_link_if_i.inputTimingPos), .inputTimingNeg(btdsp_link_if_i.inputTimingNeg),
        .loopDisableN(btdsp_link_if_i.loopDisableN), .loadStrobeN(btdsp_link_if_i.loadStrobeN),
        .readNotWrite(btdsp_link_if_i.readNotWrite), .byteLaneSelN(btdsp_link_if_i.byteLaneSelN),
        .hostOe(btdsp_link_if_i.hostOe), .devOe(btdsp_link_if_i.devOe));
    end
  end
  // ********************
  // Tasks
  // ********************
  // Compare and count; an unknown matches only an unknown in the same bit.
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Deselected lanes keep old bits; lane zero is bits 8:0.
  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n, input logic [1:0] l);
    return {l[1] ? o[17:9] : n[17:9], l[0] ? o[8:0] : n[8:0]};
  endfunction
  // Hold the command until the host takes it, with a bounded wait.
  task automatic issue(input logic w, input logic [19:0] a, input logic [17:0] d0, input logic [17:0] d1,
                       input logic [1:0] l0, input logic [1:0] l1);
    int n;
    n = 0;
    {cmdValid, cmdWrite, cmdAddr} = {1'b1, w, a};
    {cmdData0, cmdData1, cmdLaneN0, cmdLaneN1} = {d0, d1, l0, l1};
    while (cmdReady[0] !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 200)
      nErrors++;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    @(negedge ref_clk);
  endtask
  // Write a burst and follow it in the expected array.
  task automatic wr(input logic [19:0] a, input logic [17:0] d0, input logic [17:0] d1,
                    input logic [1:0] l0, input logic [1:0] l1);
    issue(1'b1, a, d0, d1, l0, l1);
    mem[int'(a)] = merge(mem[int'(a)], d0, l0);
    mem[int'(a ^ 20'h1)] = merge(mem[int'(a ^ 20'h1)], d1, l1);
  endtask
  // Take one read word after a stall of the given length.
  task automatic pop(input int stall, input logic [17:0] exp);
    int n;
    n = 0;
    repeat (stall) @(negedge ref_clk);
    while (rdValid[0] !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 100)
      nErrors++;
    chk(rdData[0], exp);
    chk(rdData[1], exp);
    rdReady = 1'b1;
    @(negedge ref_clk);
    rdReady = 1'b0;
    @(negedge ref_clk);
  endtask
  // Read a burst: the start word, then the other word of the row.
  task automatic rd(input logic [19:0] a, input int stall);
    issue(1'b0, a, 18'h0, 18'h0, 2'h3, 2'h3);
    pop(stall, mem[int'(a)]);
    pop(0, mem[int'(a ^ 20'h1)]);
  endtask
  // Print counts and the verdict, then stop.
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ********************
  // Sequence and watchdog
  // ********************
  // Reset for 12 cycles, then bursts of every kind.
  initial
  begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({17'h0, singleClkMode[0]}, 18'h0);
    chk({17'h0, singleClkMode[1]}, 18'h1);
    wr(20'h00010, 18'h12345, 18'h2ABCD, btdsp_pkg::LANES_ALL, btdsp_pkg::LANES_ALL);
    wr(20'h00013, 18'h3C3C3, 18'h05A5A, btdsp_pkg::LANES_ALL, btdsp_pkg::LANES_ALL);
    rd(20'h00010, 0);
    rd(20'h00012, 6);
    for (int i = 0; i < 4; i++)
    begin
      wr(20'h00010, {9'(i), 9'(3 - i)}, {9'(7 - i), 9'(i)}, 2'(i), 2'(3 - i));
      rd(20'h00011, i);
    end
    final_report();
  end
  // Cut a hang short well past the expected run length.
  initial
  begin
    #100000;
    nErrors++;
    final_report();
  end
endmodule // tb_burst_two_ddr_sram_port
